// File: hw/ppab_regs.vh
// register map and constants for the two-port parallel io block
`ifndef PPAB_REGS_VH
`define PPAB_REGS_VH
`define PPAB_ADDR_W        4
`define PPAB_OFF_A_LATCH   4'h0
`define PPAB_OFF_B_LATCH   4'h1
`define PPAB_OFF_A_DIR     4'h4
`define PPAB_OFF_B_DIR     4'h5
`define PPAB_OFF_A_PULLUP  4'h8
`define PPAB_OFF_KEY_CTRL  4'h9
`define PPAB_OFF_AN_SEL    4'ha
`define PPAB_OFF_KEY_STAT  4'hb
`define PPAB_DIR_RESET     8'h00
`define PPAB_PULLUP_RESET  8'h00
`define PPAB_KEY_RESET     8'h00
`define PPAB_AN_OFF        5'h1f
`define PPAB_AN_RESET      5'h1f
`define PPAB_UNMAPPED      8'h00
`endif

// File: hw/ppab_sync8.v
// two-flop synchroniser for an eight bit pin bus
`timescale 1ns/1ns
`default_nettype none
module ppab_sync8 (
	input  wire       sys_clk,
	input  wire       reset_n,
	input  wire [7:0] asyncIn,
	output reg  [7:0] syncOut
);
	reg [7:0] stage1;

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1  <= 8'h00;
			syncOut <= 8'h00;
		end else begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule // ppab_sync8
`default_nettype wire

// File: hw/ppab_ports.v
// two eight-bit bidirectional ports with register access
`timescale 1ns/1ns
`default_nettype none
`include "ppab_regs.vh"
module ppab_ports (
	input  wire                    sys_clk,
	input  wire                    reset_n,
	input  wire [`PPAB_ADDR_W-1:0] regAddr,
	input  wire [7:0]              regWrData,
	input  wire                    regWrite,
	input  wire                    regRead,
	output reg  [7:0]              regRdData,
	input  wire [7:0]              firstPortIn,
	output reg  [7:0]              firstPortOut,
	output reg  [7:0]              firstPortOe,
	output reg  [7:0]              firstPortPullupOn,
	output reg  [7:0]              keyIrqPinEnable,
	output reg                     keyIrqRequest,
	input  wire [7:0]              secondPortIn,
	output reg  [7:0]              secondPortOut,
	output reg  [7:0]              secondPortOe,
	output reg  [7:0]              analogPinSelect
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg  [7:0] firstPortLatch;
	reg  [7:0] firstPortDirection;
	reg  [7:0] firstPortPullupEnable;
	reg  [7:0] keyIrqEnableBits;
	reg  [4:0] analogChannelSelect;
	reg  [7:0] secondPortLatch;
	reg  [7:0] secondPortDirection;
	reg  [7:0] keyPrev;
	reg  [7:0] keyFlags;
	wire [7:0] firstPinSync;
	wire [7:0] secondPinSync;
	wire [7:0] keyFall;
	wire [7:0] next_anSel;
	reg  [7:0] readMux;

	// decodes the channel select into a one-hot pin mask, all zero for channels 8 and up
	function [7:0] chanMask;
		input [4:0] ch;
		begin
			chanMask = 8'h00;
			if (ch[4:3] == 2'b00)
				chanMask[ch[2:0]] = 1'b1;
		end
	endfunction

	// per-bit choice of latch or pin for a data read
	function [7:0] portView;
		input [7:0] dir;
		input [7:0] latch;
		input [7:0] pin;
		begin
			portView = (dir & latch) | (~dir & pin);
		end
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	ppab_sync8 syncFirst (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.asyncIn (firstPortIn),
		.syncOut (firstPinSync)
	);

	ppab_sync8 syncSecond (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.asyncIn (secondPortIn),
		.syncOut (secondPinSync)
	);

	// ------------------------------------------------------------
	// data latches: no reset, contents survive it
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (regWrite && regAddr == `PPAB_OFF_A_LATCH)
			firstPortLatch <= regWrData;
		if (regWrite && regAddr == `PPAB_OFF_B_LATCH)
			secondPortLatch <= regWrData;
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			firstPortDirection    <= `PPAB_DIR_RESET;
			secondPortDirection   <= `PPAB_DIR_RESET;
			firstPortPullupEnable <= `PPAB_PULLUP_RESET;
			keyIrqEnableBits      <= `PPAB_KEY_RESET;
			analogChannelSelect   <= `PPAB_AN_RESET;
		end else if (regWrite) begin
			case (regAddr)
			`PPAB_OFF_A_DIR: begin
				firstPortDirection <= regWrData;
			end
			`PPAB_OFF_B_DIR: begin
				secondPortDirection <= regWrData;
			end
			`PPAB_OFF_A_PULLUP: begin
				firstPortPullupEnable <= regWrData;
			end
			`PPAB_OFF_KEY_CTRL: begin
				keyIrqEnableBits <= regWrData;
			end
			`PPAB_OFF_AN_SEL: begin
				analogChannelSelect <= regWrData[4:0];
			end
			default: begin
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// keyboard falling-edge flags, write one to clear, set wins
	// ------------------------------------------------------------
	assign keyFall = keyPrev & ~firstPinSync & keyIrqEnableBits;

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			keyPrev  <= 8'hff;
			keyFlags <= 8'h00;
		end else begin
			keyPrev <= firstPinSync;
			if (regWrite && regAddr == `PPAB_OFF_KEY_STAT)
				keyFlags <= (keyFlags & ~regWrData) | keyFall;
			else
				keyFlags <= keyFlags | keyFall;
		end
	end

	// ------------------------------------------------------------
	// read path: data valid the cycle after the strobe only
	// ------------------------------------------------------------
	always @* begin
		case (regAddr)
		`PPAB_OFF_A_LATCH: readMux = portView(firstPortDirection,
			firstPortLatch, firstPinSync);
		`PPAB_OFF_B_LATCH: readMux = portView(secondPortDirection,
			secondPortLatch, secondPinSync);
		`PPAB_OFF_A_DIR:    readMux = firstPortDirection;
		`PPAB_OFF_B_DIR:    readMux = secondPortDirection;
		`PPAB_OFF_A_PULLUP: readMux = firstPortPullupEnable;
		`PPAB_OFF_KEY_CTRL: readMux = keyIrqEnableBits;
		`PPAB_OFF_AN_SEL:   readMux = {3'b000, analogChannelSelect};
		`PPAB_OFF_KEY_STAT: readMux = keyFlags;
		default:            readMux = `PPAB_UNMAPPED;
		endcase
	end

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			regRdData <= 8'h00;
		else if (regRead)
			regRdData <= readMux;
		else
			regRdData <= 8'h00;
	end

	// ------------------------------------------------------------
	// pin drivers, registered; take effect one edge after a write
	// ------------------------------------------------------------
	// outputs follow the registers with one flop of delay so every
	// top output comes from a flop; software sees no wait state.
	assign next_anSel = chanMask(analogChannelSelect);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			firstPortOut      <= 8'h00;
			firstPortOe       <= 8'h00;
			firstPortPullupOn <= 8'h00;
			keyIrqPinEnable   <= 8'h00;
			keyIrqRequest     <= 1'b0;
			secondPortOut     <= 8'h00;
			secondPortOe      <= 8'h00;
			analogPinSelect   <= 8'h00;
		end else begin
			firstPortOut <= firstPortLatch;
			firstPortOe  <= firstPortDirection;
			// pullup only ever on an input pin
			firstPortPullupOn <= firstPortPullupEnable &
				~firstPortDirection;
			keyIrqPinEnable <= keyIrqEnableBits;
			keyIrqRequest   <= |keyFlags;
			secondPortOut   <= secondPortLatch;
			// analog selection wins over the direction bit
			secondPortOe <= secondPortDirection &
				~next_anSel;
			analogPinSelect <= next_anSel;
		end
	end
endmodule // ppab_ports
`default_nettype wire

// File: verification/ppab_ports_checker.sv
// port-level assertions for the two-port parallel io block
`timescale 1ns/1ns
`default_nettype none
module ppab_ports_checker (
	input wire logic       sys_clk,
	input wire logic       reset_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	input wire logic [7:0] firstPortIn,
	input wire logic [7:0] firstPortOut,
	input wire logic [7:0] firstPortOe,
	input wire logic [7:0] firstPortPullupOn,
	input wire logic [7:0] keyIrqPinEnable,
	input wire logic       keyIrqRequest,
	input wire logic [7:0] secondPortIn,
	input wire logic [7:0] secondPortOut,
	input wire logic [7:0] secondPortOe,
	input wire logic [7:0] analogPinSelect
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	AST_A_DIR: assert property (regWrite && regAddr == 4'h4 |-> ##2
		firstPortOe == $past(regWrData, 2)) else $error("port A enable");
	AST_RST_DIR: assert property ($rose(reset_n) |->
		firstPortOe == 8'h00 && secondPortOe == 8'h00) else $error("reset dir");
	AST_PULL_OFF: assert property ((firstPortPullupOn & firstPortOe) == 8'h00)
		else $error("pullup on output");
	AST_PULL_ON: assert property (regWrite && regAddr == 4'h8 &&
		firstPortOe == 8'h00 |-> ##2 firstPortPullupOn == $past(regWrData, 2))
		else $error("pullup enable");
	AST_ANALOG: assert property ((secondPortOe & analogPinSelect) == 8'h00)
		else $error("analog pin driven");
	AST_AN_SEL: assert property (regWrite && regAddr == 4'ha |-> ##2
		analogPinSelect == ($past(regWrData[4:0], 2) < 5'h08 ?
		8'h01 << $past(regWrData[2:0], 2) : 8'h00)) else $error("analog select");
	AST_RD_LATCH: assert property (regRead && regAddr == 4'h0 &&
		firstPortOe == 8'hff |=> regRdData == firstPortOut) else $error("latch read");
	AST_RD_IDLE: assert property (!regRead |=> regRdData == 8'h00)
		else $error("read data outside read");
	AST_UNMAP: assert property (regRead && regAddr == 4'hf |=>
		regRdData == 8'h00) else $error("unmapped read");
	AST_OUT_B: assert property (regWrite && regAddr == 4'h1 |-> ##2
		secondPortOut == $past(regWrData, 2)) else $error("port B latch");
endmodule // ppab_ports_checker
`default_nettype wire

// File: verification/ppab_pins.sv
// board pins seen by one port: driver, pullup, external source, float
`timescale 1ns/1ns
`default_nettype none
module ppab_pins (
	input  wire logic       sys_clk,
	input  wire logic [7:0] oe,
	input  wire logic [7:0] drv,
	input  wire logic [7:0] pull,
	input  wire logic [7:0] extEn,
	input  wire logic [7:0] ext,
	output wire logic [7:0] pin
);
	logic [7:0] floatVal = 8'h55;
	// a floating line wanders so a stale level never reads as valid
	always @(posedge sys_clk) floatVal <= ~floatVal;
	assign pin = (oe & drv) | (~oe & extEn & ext) | (~oe & ~extEn & (pull | floatVal));
endmodule // ppab_pins
`default_nettype wire

// File: verification/test_ppab_ports.sv
// self-checking bench for the two-port parallel io block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_ppab_ports;
	logic       sys_clk = 0, reset_n = 0, regWrite = 0, regRead = 0, keyReq;
	logic [3:0] regAddr = 0;
	logic [7:0] regWrData = 0, regRdData, aOut, aOe, aPull, keyEn, bOut, bOe;
	logic [7:0] anSel, aPin, bPin, aExt = 0, aExtEn = 0, bExt = 0;
	int         n_mismatch = 0, tests_run = 0;
	initial forever #10 sys_clk = ~sys_clk;
	ppab_ports DUT (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .firstPortIn(aPin), .firstPortOut(aOut),
		.firstPortOe(aOe), .firstPortPullupOn(aPull), .keyIrqPinEnable(keyEn),
		.keyIrqRequest(keyReq), .secondPortIn(bPin), .secondPortOut(bOut),
		.secondPortOe(bOe), .analogPinSelect(anSel));
	ppab_pins pinA (.sys_clk(sys_clk), .oe(aOe), .drv(aOut), .pull(aPull),
		.extEn(aExtEn), .ext(aExt), .pin(aPin));
	ppab_pins pinB (.sys_clk(sys_clk), .oe(bOe), .drv(bOut), .pull(8'h00),
		.extEn(8'hff), .ext(bExt), .pin(bPin));
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 `CHK("regRdData", e, regRdData)
	endtask
	// pin sync plus output register: four edges is ample
	task automatic settle;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		`CHK("aOe", 8'h00, aOe)
		`CHK("bOe", 8'h00, bOe)
		rd(4'h4, 8'h00);
		rd(4'h5, 8'h00);
		rd(4'h8, 8'h00);
		rd(4'ha, 8'h1f);
		rd(4'hf, 8'h00);
	endtask
	task automatic t_porta;
		@(posedge sys_clk) {aExtEn, aExt} <= 16'hffa5;
		wr(4'h0, 8'h5a);
		settle;
		rd(4'h0, 8'ha5);
		wr(4'h4, 8'hf0);
		settle;
		`CHK("aOe", 8'hf0, aOe)
		`CHK("aOut", 8'h5a, aOut)
		rd(4'h0, 8'h55);
	endtask
	task automatic t_pull;
		@(posedge sys_clk) aExtEn <= 8'h00;
		wr(4'h4, 8'h00);
		wr(4'h8, 8'hff);
		settle;
		rd(4'h0, 8'hff);
		wr(4'h4, 8'h0f);
		settle;
		`CHK("aPull", 8'hf0, aPull)
		wr(4'h8, 8'h81);
		settle;
		`CHK("aPull", 8'h80, aPull)
	endtask
	task automatic t_portb;
		@(posedge sys_clk) bExt <= 8'ha0;
		wr(4'h1, 8'h3c);
		wr(4'h5, 8'hff);
		settle;
		`CHK("bOe", 8'hff, bOe)
		rd(4'h1, 8'h3c);
		wr(4'h5, 8'h0f);
		settle;
		rd(4'h1, 8'hac);
		wr(4'ha, 8'h02);
		settle;
		`CHK("anSel", 8'h04, anSel)
		`CHK("bOe", 8'h0b, bOe)
		wr(4'ha, 8'h1f);
		settle;
		`CHK("anSel", 8'h00, anSel)
	endtask
	task automatic t_key;
		@(posedge sys_clk) {aExtEn, aExt} <= 16'hffff;
		wr(4'h4, 8'h00);
		wr(4'h9, 8'h01);
		settle;
		wr(4'hb, 8'hff);
		`CHK("keyEn", 8'h01, keyEn)
		@(posedge sys_clk) aExt <= 8'hfe;
		settle;
		`CHK("keyReq", 1'b1, keyReq)
		wr(4'hb, 8'h01);
		settle;
		`CHK("keyReq", 1'b0, keyReq)
	endtask
	task automatic t_keep;
		wr(4'h0, 8'hc3);
		@(posedge sys_clk) reset_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		wr(4'h4, 8'hff);
		settle;
		rd(4'h0, 8'hc3);
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		#1 t_reset;
		t_porta;
		t_pull;
		t_portb;
		t_key;
		t_keep;
		print_verdict;
	end
endmodule // test_ppab_ports
bind ppab_ports ppab_ports_checker chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
	.regRead(regRead), .regRdData(regRdData), .firstPortIn(firstPortIn),
	.firstPortOut(firstPortOut), .firstPortOe(firstPortOe),
	.firstPortPullupOn(firstPortPullupOn), .keyIrqPinEnable(keyIrqPinEnable),
	.keyIrqRequest(keyIrqRequest), .secondPortIn(secondPortIn),
	.secondPortOut(secondPortOut), .secondPortOe(secondPortOe),
	.analogPinSelect(analogPinSelect));
`default_nettype wire
